//--- tx_shape_regs.svh
`ifndef TX_SHAPE_REGS_SVH
`define TX_SHAPE_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_EDGE_STYLE_RATE212    11'h514
`define IDX_EDGE_LENGTH_RATE212   11'h515
`define IDX_RESIDUAL_LEVEL_RATE424 11'h516
`define IDX_EDGE_TYPE_RATE424     11'h517
`define IDX_EDGE_TYPE_RATE212     11'h520
`define IDX_RESIDUAL_LEVEL_RATE212 11'h521
`define IDX_SHAPE_CTRL            11'h522
`define IDX_SHAPE_STATUS          11'h523

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STYLE_FALL_MSB 6
`define STYLE_FALL_LSB 4
`define STYLE_RISE_MSB 2
`define STYLE_RISE_LSB 0
`define LEN_DOUBLE_BIT 7
`define LEN_COUNT_MSB  4
`define TYPE_FALL_MSB  7
`define TYPE_FALL_LSB  4
`define TYPE_RISE_MSB  3
`define TYPE_RISE_LSB  0
`define CTRL_RATE_BIT  0

// ----------------------------------------------------------------
// Style codes, levels and reset values
// ----------------------------------------------------------------
`define CODE_LIN1      4'h1
`define CODE_LIN3      4'h3
`define CODE_LUT_FIXED 4'h4
`define CODE_LUT_CORR  4'h5
`define CODE_LUT_NOCOR 4'h6
`define LEVEL_FULL     8'hFF
`define CFG_RESET      8'h00

`endif

//--- tx_shape_pkg.sv
`default_nettype none
package tx_shape_pkg;
    typedef enum logic [1:0] {
        ST_FULL,
        ST_FALL,
        ST_LOW,
        ST_RISE
    } shape_state_e;

    typedef struct packed {
        logic         wr_pend;
        logic [10:0]  wr_idx;
        logic [31:0]  rdata;
        logic [7:0]   style212;
        logic [7:0]   length212;
        logic [7:0]   res424;
        logic [7:0]   type424;
        logic [7:0]   type212;
        logic [7:0]   res212;
        logic         rate424;
        shape_state_e state;
        logic [4:0]   step;
        logic         dwell;
        logic [7:0]   amp;
        logic [3:0]   style_out;
        logic [2:0]   tc_out;
        logic [1:0]   lut_out;
        logic         adapt;
        logic         corr;
    } shape_s;
endpackage
`default_nettype wire

//--- tx_edge_shaping_config.sv
`include "tx_shape_regs.svh"
`default_nettype none

// Operation
// - Firmware shaping: falling style field is falling time constant.
// - Table shaping: falling field picks falling-edge table 0 to 3.
// - Firmware shaping: low style field is rising time constant.
// - Table shaping: low style field picks rising-edge table 0 to 3.
// - Length top bit clear: each transition state lasts one carrier cycle.
// - Length top bit set: each transition state lasts two carrier cycles.
// - Doubling applies to rising and falling edges together.
// - Five-bit length field counts transition states of both edges.
// - Eight-bit residual level sets modulated amplitude, 0 to full.
// - Upper nibble of edge type is falling edge style code.
// - Lower nibble of edge type is rising edge style code.
// - Codes 1 to 3 are firmware ramps of one to three segments.
// - Code 4 is table shaping without supply adaptation.
// - Code 5 is table shaping with supply adaptation and correction.
// - Code 6 is table shaping with supply adaptation, no correction.
module tx_edge_shaping_config
    import tx_shape_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Modulation request from encoder
    input  wire logic        mod_req,
    // Shaping outputs to amplifier
    output logic      [7:0]  amplitude,
    output logic             edge_active,
    output logic      [3:0]  edge_style,
    output logic      [2:0]  edge_setting,
    output logic      [1:0]  edge_lut,
    output logic             supply_adapt,
    output logic             correction
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    shape_s s;
    shape_s next_s;

    logic        ahb_go;
    logic        hit;
    logic [10:0] idx;
    logic [7:0]  typ;
    logic [7:0]  res;
    logic [3:0]  fall_code;
    logic [3:0]  rise_code;
    logic [4:0]  nst;
    logic        dbl;
    logic        fall_ok;
    logic        rise_ok;
    logic [7:0]  diff;

    function automatic logic is_fw(input logic [3:0] c);
        return c >= `CODE_LIN1 && c <= `CODE_LIN3;
    endfunction

    function automatic logic is_lut(input logic [3:0] c);
        return c >= `CODE_LUT_FIXED && c <= `CODE_LUT_NOCOR;
    endfunction

    // Linear share of the swing after k of n states
    function automatic logic [7:0] ramp(input logic [7:0] d,
                                        input logic [4:0] k,
                                        input logic [4:0] n);
        logic [12:0] p;
        p = {5'h00, d} * {8'h00, k};
        return 8'(p / {8'h00, n});
    endfunction

    assign ahb_go    = hsel & htrans[1] & hready;
    assign idx       = haddr[12:2];
    assign hit       = (haddr[31:13] == 19'h0) &&
                       (idx inside {`IDX_EDGE_STYLE_RATE212,
                                    `IDX_EDGE_LENGTH_RATE212,
                                    `IDX_RESIDUAL_LEVEL_RATE424,
                                    `IDX_EDGE_TYPE_RATE424,
                                    `IDX_EDGE_TYPE_RATE212,
                                    `IDX_RESIDUAL_LEVEL_RATE212,
                                    `IDX_SHAPE_CTRL});

    // Active rate configuration
    assign typ       = s.rate424 ? s.type424 : s.type212;
    assign res       = s.rate424 ? s.res424 : s.res212;
    assign fall_code = typ[`TYPE_FALL_MSB:`TYPE_FALL_LSB];
    assign rise_code = typ[`TYPE_RISE_MSB:`TYPE_RISE_LSB];
    assign nst       = s.length212[`LEN_COUNT_MSB:0];
    assign dbl       = s.length212[`LEN_DOUBLE_BIT];
    // Unsupported codes or zero states give an abrupt edge
    assign fall_ok   = (is_fw(fall_code) | is_lut(fall_code)) &&
                       nst != 5'h0;
    assign rise_ok   = (is_fw(rise_code) | is_lut(rise_code)) &&
                       nst != 5'h0;
    assign diff      = `LEVEL_FULL - res;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] code;
        logic [2:0] fld;
        code   = 4'h0;
        fld    = 3'h0;
        next_s = s;

        // Data phase write, whole low byte stored except control (bit 0 only), reserved bits included
        if (s.wr_pend) begin
            case (s.wr_idx)
                `IDX_EDGE_STYLE_RATE212:     next_s.style212  = hwdata[7:0];
                `IDX_EDGE_LENGTH_RATE212:    next_s.length212 = hwdata[7:0];
                `IDX_RESIDUAL_LEVEL_RATE424: next_s.res424    = hwdata[7:0];
                `IDX_EDGE_TYPE_RATE424:      next_s.type424   = hwdata[7:0];
                `IDX_EDGE_TYPE_RATE212:      next_s.type212   = hwdata[7:0];
                `IDX_RESIDUAL_LEVEL_RATE212: next_s.res212    = hwdata[7:0];
                `IDX_SHAPE_CTRL: next_s.rate424 = hwdata[`CTRL_RATE_BIT];
                default: ;
            endcase
        end

        // Address phase capture; read data from post-write values
        next_s.wr_pend = ahb_go & hwrite & hit;
        next_s.wr_idx  = idx;
        next_s.rdata   = 32'h0;
        if (ahb_go && !hwrite && haddr[31:13] == 19'h0) begin
            case (idx)
                `IDX_EDGE_STYLE_RATE212: next_s.rdata[7:0] = next_s.style212;
                `IDX_EDGE_LENGTH_RATE212: next_s.rdata[7:0] = next_s.length212;
                `IDX_RESIDUAL_LEVEL_RATE424: next_s.rdata[7:0] = next_s.res424;
                `IDX_EDGE_TYPE_RATE424: next_s.rdata[7:0] = next_s.type424;
                `IDX_EDGE_TYPE_RATE212: next_s.rdata[7:0] = next_s.type212;
                `IDX_RESIDUAL_LEVEL_RATE212: next_s.rdata[7:0] = next_s.res212;
                `IDX_SHAPE_CTRL: next_s.rdata[0] = next_s.rate424;
                `IDX_SHAPE_STATUS: next_s.rdata[14:0] =
                    {s.state, s.step, s.amp};
                default: ;
            endcase
        end

        // Envelope sequencer
        case (s.state)
            ST_FULL: begin
                next_s.amp = `LEVEL_FULL;
                if (mod_req) begin
                    next_s.dwell = 1'b0;
                    next_s.step  = 5'h1;
                    if (fall_ok) begin
                        next_s.state = ST_FALL;
                        next_s.amp   = `LEVEL_FULL -
                            ramp(diff, 5'h1, nst);
                    end else begin
                        next_s.state = ST_LOW;
                        next_s.amp   = res;
                    end
                end
            end
            ST_FALL: begin
                // Second cycle only when doubled; a rewrite cannot stall it
                if (dbl && !s.dwell) begin
                    next_s.dwell = 1'b1;
                end else begin
                    next_s.dwell = 1'b0;
                    if (s.step >= nst) begin
                        next_s.state = ST_LOW;
                        next_s.amp   = res;
                    end else begin
                        next_s.step = s.step + 5'h1;
                        next_s.amp  = `LEVEL_FULL -
                            ramp(diff, s.step + 5'h1, nst);
                    end
                end
            end
            ST_LOW: begin
                next_s.amp = res;
                if (!mod_req) begin
                    next_s.dwell = 1'b0;
                    next_s.step  = 5'h1;
                    if (rise_ok) begin
                        next_s.state = ST_RISE;
                        next_s.amp   = res + ramp(diff, 5'h1, nst);
                    end else begin
                        next_s.state = ST_FULL;
                        next_s.amp   = `LEVEL_FULL;
                    end
                end
            end
            ST_RISE: begin
                if (dbl && !s.dwell) begin
                    next_s.dwell = 1'b1;
                end else begin
                    next_s.dwell = 1'b0;
                    if (s.step >= nst) begin
                        next_s.state = ST_FULL;
                        next_s.amp   = `LEVEL_FULL;
                    end else begin
                        next_s.step = s.step + 5'h1;
                        next_s.amp  = res +
                            ramp(diff, s.step + 5'h1, nst);
                    end
                end
            end
            default: next_s.state = ST_FULL;
        endcase

        // Shaping selection for the edge in progress
        if (next_s.state == ST_FALL) begin
            code = fall_code;
            fld  = s.style212[`STYLE_FALL_MSB:`STYLE_FALL_LSB];
        end else if (next_s.state == ST_RISE) begin
            code = rise_code;
            fld  = s.style212[`STYLE_RISE_MSB:`STYLE_RISE_LSB];
        end
        next_s.style_out = code;
        next_s.tc_out    = is_fw(code) ? fld : 3'h0;
        next_s.lut_out   = is_lut(code) ? fld[1:0] : 2'h0;
        next_s.adapt     = (code == `CODE_LUT_CORR) ||
                           (code == `CODE_LUT_NOCOR);
        next_s.corr      = (code == `CODE_LUT_CORR);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s           <= '0;
            s.style212  <= `CFG_RESET;
            s.length212 <= `CFG_RESET;
            s.state     <= ST_FULL;
            s.amp       <= `LEVEL_FULL;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign hrdata       = s.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign amplitude    = s.amp;
    assign edge_active  = (s.state == ST_FALL) || (s.state == ST_RISE);
    assign edge_style   = s.style_out;
    assign edge_setting = s.tc_out;
    assign edge_lut     = s.lut_out;
    assign supply_adapt = s.adapt;
    assign correction   = s.corr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    fall_tc_a: assert property (
        s.state == ST_FALL && is_fw($past(fall_code)) |->
        edge_setting == $past(s.style212[6:4]) &&
        edge_style == $past(fall_code))
        else $error("falling time constant not taken from style byte");
    fall_lut_a: assert property (
        s.state == ST_FALL && is_lut($past(fall_code)) |->
        edge_lut == $past(s.style212[5:4]) && edge_setting == 3'h0)
        else $error("falling table index wrong");
    rise_tc_a: assert property (
        s.state == ST_RISE && is_fw($past(rise_code)) |->
        edge_setting == $past(s.style212[2:0]) &&
        edge_style == $past(rise_code))
        else $error("rising time constant not taken from style byte");
    rise_lut_a: assert property (
        s.state == ST_RISE && is_lut($past(rise_code)) |->
        edge_lut == $past(s.style212[1:0]))
        else $error("rising table index wrong");
    dwell_one_a: assert property (
        s.state == ST_FALL && !dbl && s.step < nst && !s.wr_pend |=>
        s.step == $past(s.step) + 5'h1)
        else $error("single-cycle state did not advance");
    dwell_two_a: assert property (
        s.state == ST_RISE && dbl && !s.dwell && s.step < nst &&
        !s.wr_pend |=> s.step == $past(s.step) ##1
        s.step == $past(s.step, 2) + 5'h1)
        else $error("double-cycle state length wrong");
    edge_end_a: assert property (
        s.state == ST_FALL && s.step == nst && s.dwell == dbl |=>
        s.state == ST_LOW && amplitude == $past(res))
        else $error("falling edge did not end at state count");
    low_level_a: assert property (
        s.state == ST_LOW && $past(s.state) == ST_LOW |->
        amplitude == $past(res))
        else $error("modulated amplitude not residual level");
    full_level_a: assert property (
        s.state == ST_FULL && $past(s.state) == ST_FULL |->
        amplitude == 8'hFF)
        else $error("unmodulated amplitude not full");
    fall_mono_a: assert property (
        s.state == ST_FALL && !$past(s.wr_pend) |=>
        amplitude <= $past(amplitude))
        else $error("falling amplitude rose");
    bad_code_a: assert property (
        s.state == ST_FULL && mod_req && !fall_ok |=>
        s.state == ST_LOW && !edge_active)
        else $error("unsupported code produced an edge");
    lut_flags_a: assert property (
        (edge_style == 4'h4 |-> !supply_adapt && !correction) and
        (edge_style == 4'h5 |-> supply_adapt && correction) and
        (edge_style == 4'h6 |-> supply_adapt && !correction))
        else $error("supply adaptation flags wrong");
    rise_mono_a: assert property (
        s.state == ST_RISE && !$past(s.wr_pend) |=>
        amplitude >= $past(amplitude))
        else $error("rising amplitude fell");
    rise_end_a: assert property (
        s.state == ST_RISE && s.step == nst && s.dwell == dbl |=>
        s.state == ST_FULL && amplitude == 8'hFF)
        else $error("rising edge did not end at state count");
    idle_outputs_a: assert property (
        !edge_active |-> edge_style == 4'h0 && edge_setting == 3'h0 &&
        edge_lut == 2'h0 && !supply_adapt && !correction)
        else $error("shaping outputs set outside an edge");
    rate_sel_a: assert property (
        s.state == ST_LOW && $past(s.state) == ST_LOW &&
        $past(s.rate424) |-> amplitude == $past(s.res424))
        else $error("residual level not taken from selected rate");

    fall_done_c: cover property (
        s.state == ST_FALL ##1 s.state == ST_LOW);
    rise_slow_c: cover property (
        s.state == ST_RISE && dbl ##[1:64] s.state == ST_FULL);
    lut_corr_c: cover property (edge_style == 4'h5);
    abrupt_fall_c: cover property (s.state == ST_FULL && mod_req && !fall_ok);

endmodule // tx_edge_shaping_config

`default_nettype wire

//--- pa_model.sv
`default_nettype none

// ----------------------------------------------------------------
// Amplifier model: measures the length of each shaped edge
// ----------------------------------------------------------------
module pa_model (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Drive from the shaper
    input  wire logic [7:0] amplitude,
    input  wire logic       edge_active,
    // Measurement
    output logic      [7:0] edge_len
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] run;

    // Count edge cycles, latch the count once the edge is over
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= 8'h00;
            edge_len <= 8'h00;
        end else if (edge_active === 1'b1) begin
            run <= run + 8'h01;
        end else if (run != 8'h00) begin
            edge_len <= run;
            run <= 8'h00;
        end
    end
endmodule // pa_model

`default_nettype wire

//--- tb_tx_edge_shaping_config.sv
`include "tx_shape_regs.svh"
`default_nettype none

module tb_tx_edge_shaping_config
    import tx_shape_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        hclk, hresetn, hsel, hwrite, mod_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, edge_setting;
    logic        hreadyout, hresp, edge_active, supply_adapt, correction;
    logic [7:0]  amplitude, edge_len, style, len_b, typ, res;
    logic [3:0]  edge_style;
    logic [1:0]  edge_lut;
    wire  logic  hready;
    int          n_errors, n_compared;
    assign hready = hreadyout;

    tx_edge_shaping_config tx_edge_shaping_config_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .mod_req(mod_req), .amplitude(amplitude),
        .edge_active(edge_active), .edge_style(edge_style),
        .edge_setting(edge_setting), .edge_lut(edge_lut),
        .supply_adapt(supply_adapt), .correction(correction));

    pa_model pa_model_inst (
        .hclk(hclk), .hresetn(hresetn), .amplitude(amplitude),
        .edge_active(edge_active), .edge_len(edge_len));

    // ----------------------------------------------------------------
    // Checking and reporting
    // ----------------------------------------------------------------
    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic cmp_bus(string nm, logic [31:0] exp, logic [31:0] got);
        check(nm, exp, got);
    endtask

    task automatic cmp_out(string nm, logic [31:0] exp, logic [31:0] got);
        check(nm, exp, got);
    endtask

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    function automatic logic [31:0] ba(input logic [10:0] idx);
        return {19'h0, idx, 2'b00};
    endfunction

    // Bounded wait for hready at a rising edge
    task automatic wait_ready;
        for (int i = 0; i < 20; i++) begin
            @(posedge hclk);
            if (hready === 1'b1) return;
        end
        n_errors++;
        finish_test();
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, a, wd, dummy);
    endtask

    // ----------------------------------------------------------------
    // Reference model of one edge, compared every cycle
    // ----------------------------------------------------------------
    task automatic run_edge(input logic fall);
        int code, n, d, len, k, tgt, ts, tl;
        int q[$];
        logic [2:0] fld;
        code = fall ? typ[7:4] : typ[3:0];
        n = len_b[4:0];
        d = len_b[7] ? 2 : 1;
        fld = fall ? style[6:4] : style[2:0];
        len = (code >= 1 && code <= 6 && n > 0) ? n * d : 0;
        tgt = fall ? res : 255;
        ts = code <= 3 ? fld : 0;
        tl = code >= 4 ? fld[1:0] : 0;
        // Expected amplitude of every edge cycle, in order
        for (int c = 1; c <= len; c++) begin
            k = (255 - res) * ((c - 1) / d + 1) / n;
            q.push_back(fall ? 255 - k : res + k);
        end
        mod_req <= fall;
        for (int c = 1; c <= len; c++) begin
            @(posedge hclk);
            #1;
            cmp_out("amplitude", q.pop_front(), amplitude);
            cmp_out("edge_active", 1, edge_active);
            cmp_out("edge_style", code, edge_style);
            cmp_out("edge_setting", ts, edge_setting);
            cmp_out("edge_lut", tl, edge_lut);
            cmp_out("supply_adapt", code >= 5, supply_adapt);
            cmp_out("correction", code == 5, correction);
        end
        @(posedge hclk);
        #1;
        cmp_out("amplitude", tgt, amplitude);
        cmp_out("edge_active", 0, edge_active);
        cmp_out("edge_style", 0, edge_style);
        @(posedge hclk);
        #1;
        if (len > 0) cmp_out("edge_len", len, edge_len);
        @(posedge hclk);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (100000) @(posedge hclk);
        n_errors++;
        finish_test();
    end

    initial begin
        logic [10:0] idx [8];
        logic [31:0] v, w;
        logic        rate;
        int          nsel;
        idx = '{`IDX_EDGE_STYLE_RATE212, `IDX_EDGE_LENGTH_RATE212,
                `IDX_RESIDUAL_LEVEL_RATE424, `IDX_EDGE_TYPE_RATE424,
                `IDX_EDGE_TYPE_RATE212, `IDX_RESIDUAL_LEVEL_RATE212,
                `IDX_SHAPE_CTRL, `IDX_SHAPE_STATUS};
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, mod_req} = '0;
        hsize = 3'h2;
        n_errors = 0;
        n_compared = 0;
        void'($urandom(2789));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, then write and read back every register
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ba(idx[i]), 32'h0, v);
            cmp_bus("reset read", i == 7 ? 32'hFF : 32'h0, v);
        end
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            bus_wr(ba(idx[i]), w);
            bus(1'b0, ba(idx[i]), 32'h0, v);
            cmp_bus("readback", i == 7 ? 32'hFF :
                    (i == 6 ? w & 32'h1 : w & 32'hFF), v);
        end
        // Unmapped address reads zero and ignores writes
        bus_wr(32'h0000_1460, 32'hA5);
        bus(1'b0, 32'h0000_1460, 32'h0, v);
        cmp_bus("unmapped", 32'h0, v);
        // Edge sweep over codes, lengths, doubling, levels and rates
        for (int t = 0; t < 24; t++) begin
            rate = 1'($urandom_range(1, 0));
            style = 8'($urandom);
            len_b = 8'($urandom);
            nsel = t % 5;
            len_b[4:0] = nsel == 0 ? 5'd0 : nsel == 1 ? 5'd1 : nsel == 2 ?
                         5'd2 : nsel == 3 ? 5'd31 : 5'($urandom_range(30, 3));
            len_b[7] = 1'(t % 2);
            typ = {4'(t % 8), 4'((t + 3) % 8)};
            res = t % 6 == 0 ? 8'h00 : t % 6 == 1 ? 8'hFF : 8'($urandom);
            bus_wr(ba(`IDX_SHAPE_CTRL), {31'h0, rate});
            bus_wr(ba(`IDX_EDGE_STYLE_RATE212), {24'h0, style});
            bus_wr(ba(`IDX_EDGE_LENGTH_RATE212), {24'h0, len_b});
            bus_wr(ba(rate ? `IDX_EDGE_TYPE_RATE424 : `IDX_EDGE_TYPE_RATE212),
                   {24'h0, typ});
            bus_wr(ba(rate ? `IDX_RESIDUAL_LEVEL_RATE424 :
                      `IDX_RESIDUAL_LEVEL_RATE212), {24'h0, res});
            // Unselected rate holds different bytes
            bus_wr(ba(rate ? `IDX_EDGE_TYPE_RATE212 : `IDX_EDGE_TYPE_RATE424),
                   $urandom);
            bus_wr(ba(rate ? `IDX_RESIDUAL_LEVEL_RATE212 :
                      `IDX_RESIDUAL_LEVEL_RATE424), $urandom);
            run_edge(1'b1);
            run_edge(1'b0);
        end
        finish_test();
    end
endmodule // tb_tx_edge_shaping_config

`default_nettype wire
